// file: rtl/mdo_output_stage.sv
// macrocell output stage: or, delay, polarity and driver source select for nine channels
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module mdo_output_stage #(
    parameter int NCH = mdo_pkg::NUM_CH
) (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic [NCH-1:0]        func_a,
    input  wire logic [NCH-1:0]        func_b,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    output logic [NCH-1:0]             drv_out,
    output logic [NCH-1:0]             drv_oe,
    output logic [NCH-1:0]             pulldown_en,
    output logic [NCH-1:0]             fb_to_cell,
    output logic                       timebase_clk
);
    typedef struct packed {
        mdo_pkg::mdo_cfg_type [NCH-1:0] cfg;
        logic [mdo_pkg::PRESC_W-1:0]    presc;
        logic                           tb;
        logic                           tick;
        logic [NCH-1:0]                 out;
        logic [NCH-1:0]                 oe;
        logic [NCH-1:0]                 pd;
        logic [NCH-1:0]                 fb;
        mdo_pkg::mdo_wb_rsp_type        wb;
    } mdo_state_type;

    mdo_state_type  st_ff;
    mdo_state_type  nxt_st;
    logic [NCH-1:0] ored;
    logic [NCH-1:0] delayed;
    logic [NCH-1:0] polar;
    logic [NCH-1:0] fb_masked;

    function automatic logic [12:0] clamp_dly(input logic [31:0] v);
        clamp_dly = (v[12:0] > mdo_pkg::MAX_DLY_TICKS || v[31:13] != '0)
                  ? mdo_pkg::MAX_DLY_TICKS : v[12:0];
    endfunction

    function automatic logic [3:0] chan_of(input logic [7:0] a);
        chan_of = a[7:4];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign ored[g] = func_a[g] | func_b[g];
            mdo_delay_stage u_dly (
                .sys_clk    (sys_clk),
                .nrst       (nrst),
                .tick       (st_ff.tick),
                .din        (ored[g]),
                .rise_ticks (st_ff.cfg[g].rise),
                .fall_ticks (st_ff.cfg[g].fall),
                .dout       (delayed[g])
            );
            assign polar[g]     = delayed[g] ^ st_ff.cfg[g].inv;
            // own bit left to consumer
            // limitation: the vector reaches every cell unmasked; each consumer
            // must drop its own bit, so cell g never samples fb_masked[g]
            assign fb_masked[g] = delayed[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [3:0]  ch;
        logic        hit;
        logic [31:0] rd;
        nxt_st = st_ff;
        ch     = chan_of(wb_adr_i);
        hit    = 1'b0;
        rd     = 32'h0000_0000;

        // timebase: a tick paces delays; the clock pin toggles at the tick rate
        // one shared prescaler: all stages tick together, so a hold-off
        // may end up to one tick early, traded for a single counter
        if (32'(st_ff.presc) == mdo_pkg::TICK_CYC - 1) begin
            nxt_st.presc = '0;
            nxt_st.tick  = 1'b1;
            nxt_st.tb    = ~st_ff.tb;
        end else begin
            nxt_st.presc = st_ff.presc + 1'b1;
            nxt_st.tick  = 1'b0;
        end

        // wishbone classic: one-cycle ack, dropped in the next cycle
        // ack gated by its own flag so a held strobe is not served twice
        nxt_st.wb.ack = 1'b0;
        if (wb_cyc_i && wb_stb_i && !st_ff.wb.ack) begin
            nxt_st.wb.ack = 1'b1;
            if (wb_adr_i < mdo_pkg::OFS_DRV_LVL && 32'(ch) < NCH) begin
                hit = 1'b1;
                unique case (wb_adr_i[3:0])
                    mdo_pkg::OFS_CTRL[3:0]: begin
                        rd[3:0] = {st_ff.cfg[ch].lvl, st_ff.cfg[ch].inv, st_ff.cfg[ch].src};
                        if (wb_we_i && wb_sel_i[0]) begin
                            nxt_st.cfg[ch].src = wb_dat_i[mdo_pkg::CTRL_SRC_LSB +: 2];
                            nxt_st.cfg[ch].inv = wb_dat_i[mdo_pkg::CTRL_INV_BIT];
                            nxt_st.cfg[ch].lvl = wb_dat_i[mdo_pkg::CTRL_LVL_BIT];
                        end
                    end
                    mdo_pkg::OFS_DLY_RISE[3:0]: begin
                        rd[12:0] = st_ff.cfg[ch].rise;
                        // both low lanes needed: half a count would arm a wrong hold-off
                        // rise delay write
                        if (wb_we_i && wb_sel_i[1:0] == 2'h3) begin
                            nxt_st.cfg[ch].rise = clamp_dly(wb_dat_i);
                        end
                    end
                    mdo_pkg::OFS_DLY_FALL[3:0]: begin
                        rd[12:0] = st_ff.cfg[ch].fall;
                        // a rewrite mid-count applies at once to the pending edge
                        // fall delay write
                        if (wb_we_i && wb_sel_i[1:0] == 2'h3) begin
                            nxt_st.cfg[ch].fall = clamp_dly(wb_dat_i);
                        end
                    end
                    // status: pin level, delayed result, or input
                    mdo_pkg::OFS_STATUS[3:0]: begin
                        rd[2:0] = {st_ff.out[ch], delayed[ch], ored[ch]};
                    end
                    default: begin
                        hit = 1'b0;
                    end
                endcase
            end else if (wb_adr_i == mdo_pkg::OFS_DRV_LVL) begin
                rd[NCH-1:0] = st_ff.out;
            end else if (wb_adr_i == mdo_pkg::OFS_SRC_MASK) begin
                rd[NCH-1:0] = st_ff.fb;
            end
        end
        // unmapped reads return zero, writes dropped
        nxt_st.wb.dat = hit || wb_adr_i == mdo_pkg::OFS_DRV_LVL
                      || wb_adr_i == mdo_pkg::OFS_SRC_MASK ? rd : 32'h0000_0000;

        // inversion touches the logic source only; host level and clock
        // reach the pin exactly as written or generated
        for (int i = 0; i < NCH; i++) begin
            unique case (mdo_pkg::mdo_src_type'(st_ff.cfg[i].src))
                mdo_pkg::SRC_LOGIC: begin
                    nxt_st.out[i] = polar[i];
                    nxt_st.oe[i]  = 1'b1;
                    nxt_st.pd[i]  = 1'b0;
                end
                mdo_pkg::SRC_HOST: begin
                    nxt_st.out[i] = st_ff.cfg[i].lvl;
                    nxt_st.oe[i]  = 1'b1;
                    nxt_st.pd[i]  = 1'b0;
                end
                mdo_pkg::SRC_CLOCK: begin
                    nxt_st.out[i] = st_ff.tb;
                    nxt_st.oe[i]  = 1'b1;
                    nxt_st.pd[i]  = 1'b0;
                end
                mdo_pkg::SRC_OFF: begin
                    nxt_st.out[i] = 1'b0;
                    nxt_st.oe[i]  = 1'b0;
                    nxt_st.pd[i]  = 1'b1;
                end
            endcase
        end
        nxt_st.fb = fb_masked;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff.cfg   <= '0;
            st_ff.presc <= '0;
            st_ff.tb    <= 1'b0;
            st_ff.tick  <= 1'b0;
            st_ff.out   <= '0;
            st_ff.oe    <= '0;
            // pins pulled down until a source is chosen
            st_ff.pd    <= '1;
            st_ff.fb    <= '0;
            st_ff.wb    <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // every output straight from the state register
    assign wb_dat_o     = st_ff.wb.dat;
    assign wb_ack_o     = st_ff.wb.ack;
    assign drv_out      = st_ff.out;
    assign drv_oe       = st_ff.oe;
    assign pulldown_en  = st_ff.pd;
    assign fb_to_cell   = st_ff.fb;
    assign timebase_clk = st_ff.tb;
endmodule

// file: rtl/mdo_pkg.sv
// package: constants, field layouts and carrier types of the macrocell output stage
package mdo_pkg;

    localparam int          NUM_CH        = 9;
    localparam int          DLY_W         = 13;
    // max delay 500 ms; timebase tick every 100 us
    localparam int          MAX_DLY_MS    = 500;
    localparam int          TICK_US       = 100;
    localparam int          CLK_MHZ       = 10;
    localparam int          TICK_CYC      = TICK_US * CLK_MHZ;
    localparam logic [12:0] MAX_DLY_TICKS = 13'(MAX_DLY_MS * 1000 / TICK_US);
    localparam logic [12:0] DLY_RST       = 13'h0000;
    localparam int          PRESC_W       = 10;

    // wishbone register map, one channel per 16-byte stride
    localparam logic [7:0]  OFS_CH_BASE   = 8'h00;
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_DLY_RISE  = 8'h04;
    localparam logic [7:0]  OFS_DLY_FALL  = 8'h08;
    localparam logic [7:0]  OFS_STATUS    = 8'h0c;
    localparam logic [7:0]  OFS_DRV_LVL   = 8'h90;
    localparam logic [7:0]  OFS_SRC_MASK  = 8'h94;

    // ctrl field positions
    localparam int          CTRL_SRC_LSB  = 0;
    localparam int          CTRL_INV_BIT  = 2;
    localparam int          CTRL_LVL_BIT  = 3;
    localparam logic [1:0]  SRC_RST       = 2'h0;

    typedef enum logic [1:0] {
        SRC_OFF   = 2'h0,
        SRC_LOGIC = 2'h1,
        SRC_HOST  = 2'h2,
        SRC_CLOCK = 2'h3
    } mdo_src_type;

    typedef struct packed {
        logic [1:0]  src;
        logic        inv;
        logic        lvl;
        logic [12:0] rise;
        logic [12:0] fall;
    } mdo_cfg_type;

    typedef struct packed {
        logic        state;
        logic [12:0] cnt;
    } mdo_dly_type;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } mdo_wb_rsp_type;

endpackage

// file: rtl/mdo_delay_stage.sv
// programmable_delay_stage: separate rise and fall hold-off counted in timebase ticks
`timescale 1ns/1ps
module mdo_delay_stage (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  tick,
    input  wire logic                  din,
    input  wire logic [12:0]           rise_ticks,
    input  wire logic [12:0]           fall_ticks,
    output logic                       dout
);
    mdo_pkg::mdo_dly_type st_ff;
    mdo_pkg::mdo_dly_type nxt_st;
    logic [12:0]          target;

    always_comb begin
        nxt_st = st_ff;
        target = din ? rise_ticks : fall_ticks;
        if (din == st_ff.state) begin
            nxt_st.cnt = 13'h0000;
        end else if (target == 13'h0000 || (tick && st_ff.cnt + 13'h0001 >= target)) begin
            nxt_st.state = din;
            nxt_st.cnt   = 13'h0000;
        end else if (tick) begin
            nxt_st.cnt = st_ff.cnt + 13'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.state;
endmodule

// file: dv/mdo_output_stage_properties.sv
// checker: port-level properties of the macrocell output stage
`timescale 1ns/1ps
module mdo_output_stage_properties #(
    parameter int NCH = mdo_pkg::NUM_CH
) (
    input wire logic            sys_clk,
    input wire logic            nrst,
    input wire logic [NCH-1:0]  func_a,
    input wire logic [NCH-1:0]  func_b,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_we_i,
    input wire logic [7:0]      wb_adr_i,
    input wire logic [31:0]     wb_dat_i,
    input wire logic [3:0]      wb_sel_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    input wire logic [NCH-1:0]  drv_out,
    input wire logic [NCH-1:0]  drv_oe,
    input wire logic [NCH-1:0]  pulldown_en,
    input wire logic [NCH-1:0]  fb_to_cell,
    input wire logic            timebase_clk
);
    logic        tb_q_ff;
    logic        seen_ff;
    logic [10:0] cnt_ff;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // first toggle after reset has no reference, so it only arms the count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tb_q_ff <= 1'b0;
            seen_ff <= 1'b0;
            cnt_ff  <= 11'h000;
        end else begin
            tb_q_ff <= timebase_clk;
            seen_ff <= seen_ff | (timebase_clk != tb_q_ff);
            cnt_ff  <= (timebase_clk != tb_q_ff) ? 11'h000 : cnt_ff + 11'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_follows_req : assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_one_cycle : assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_no_ack_idle : assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_dat_zero_idle : assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_reset_disabled : assert property ($rose(nrst) |-> pulldown_en == {NCH{1'b1}}
        && drv_oe == '0 && fb_to_cell == '0) else $error("outputs not disabled at reset");
    a_pulldown_quiet : assert property ((pulldown_en & (drv_oe | drv_out)) == '0)
        else $error("pulled-down channel drives");
    a_drive_or_pull : assert property ((drv_oe | pulldown_en) == {NCH{1'b1}})
        else $error("channel neither driven nor pulled down");
    a_timebase_period : assert property (seen_ff && timebase_clk != tb_q_ff
        |-> cnt_ff == 11'd999) else $error("timebase half period wrong");
    c_write : cover property (wb_ack_o && wb_we_i);
    c_drive : cover property (|drv_oe);
    c_fb : cover property (|fb_to_cell);
endmodule
bind mdo_output_stage mdo_output_stage_properties #(.NCH(NCH)) mdo_output_stage_properties_inst (.*);

// file: dv/mdo_enable_sink.sv
// far-side model: enable inputs seeing the driver pins
`timescale 1ns/1ps
module mdo_enable_sink (
    input  wire logic [8:0] drv_out,
    input  wire logic [8:0] drv_oe,
    input  wire logic [8:0] pulldown_en,
    output logic      [8:0] pin_lvl
);
    // driven level or pulldown
    // an undriven line without pulldown floats, shown as the inverse level
    assign pin_lvl = (drv_oe & drv_out) | (~drv_oe & ~pulldown_en & ~drv_out);
endmodule

// file: dv/test_macrocell_delay_output_select.sv
// testbench: register-driven checks of the macrocell output stage
`timescale 1ns/1ps
module test_macrocell_delay_output_select;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [8:0]  func_a = 9'h000, func_b = 9'h000;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'hf;
    logic        wb_ack_o, timebase_clk, b;
    logic [8:0]  drv_out, drv_oe, pulldown_en, fb_to_cell, pin_lvl;
    int          num_errors = 0, checks = 0, n;
    mdo_output_stage mdo_output_stage_inst (.*);
    mdo_enable_sink mdo_enable_sink_inst (.*);
    initial forever #50 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        chk("ack", 32'h1, {31'h0, wb_ack_o});
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #5_000_000;
        num_errors++;
        give_verdict;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        chk("pulldown", 32'h1ff, {23'h0, pulldown_en});
        bus(8'h04, 1'b0, 32'h0);
        chk("rise reset", 32'h0, rd);
        bus(8'ha0, 1'b1, 32'hffff);
        bus(8'ha0, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(8'h14, 1'b1, 32'h0001_0000);
        bus(8'h14, 1'b0, 32'h0);
        chk("rise clamp", 32'(mdo_pkg::MAX_DLY_TICKS), rd);
        for (int c = 0; c < 9; c++) bus(8'(c * 16), 1'b1, 32'ha);
        repeat (3) @(posedge sys_clk);
        chk("host high", 32'h1ff, {23'h0, pin_lvl});
        for (int c = 0; c < 9; c++) bus(8'(c * 16), 1'b1, 32'h2);
        repeat (3) @(posedge sys_clk);
        chk("host low", 32'h0, {23'h0, pin_lvl});
        bus(8'h20, 1'b1, 32'h3);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            b = pin_lvl[2];
            do begin @(posedge sys_clk); n++; end while (pin_lvl[2] === b && n < 3000);
        end
        chk("clock half period", 32'd1000, 32'(n));
        chk("timebase pin", {31'h0, timebase_clk}, {31'h0, pin_lvl[2]});
        bus(8'h00, 1'b1, 32'h1);
        bus(8'h04, 1'b1, 32'h2);
        bus(8'h08, 1'b1, 32'h3);
        func_b <= 9'h001;
        repeat (1000) @(posedge sys_clk);
        chk("fb early", 32'h0, {23'h0, fb_to_cell});
        n = 0;
        while (fb_to_cell[0] !== 1'b1 && n < 2100) begin @(posedge sys_clk); n++; end
        chk("fb rise", 32'h1, {23'h0, fb_to_cell});
        chk("pin follows", 32'h1, {31'h0, pin_lvl[0]});
        bus(8'h0c, 1'b0, 32'h0);
        chk("status", 32'h7, rd);
        bus(8'h94, 1'b0, 32'h0);
        chk("fb vector", 32'h1, rd);
        func_b <= 9'h000;
        repeat (1500) @(posedge sys_clk);
        func_b <= 9'h001;
        repeat (4000) @(posedge sys_clk);
        chk("glitch held", 32'h1, {31'h0, fb_to_cell[0]});
        bus(8'h00, 1'b1, 32'h5);
        repeat (3) @(posedge sys_clk);
        chk("pin inverted", 32'h0, {31'h0, pin_lvl[0]});
        func_b <= 9'h000;
        repeat (2000) @(posedge sys_clk);
        chk("fall pending", 32'h1, {31'h0, fb_to_cell[0]});
        repeat (2000) @(posedge sys_clk);
        chk("fb fall", 32'h0, {31'h0, fb_to_cell[0]});
        chk("pin inv fall", 32'h1, {31'h0, pin_lvl[0]});
        func_a <= 9'h001;
        repeat (3100) @(posedge sys_clk);
        chk("fb from func a", 32'h1, {31'h0, fb_to_cell[0]});
        bus(8'h20, 1'b1, 32'h0);
        repeat (3) @(posedge sys_clk);
        chk("pulldown back", 32'h004, {23'h0, pulldown_en});
        chk("pin pulled", 32'h0, {31'h0, pin_lvl[2]});
        give_verdict;
    end
endmodule
